// file: bench/fdx_drive_model.sv
// drive stand-in: id fields, data marks, data bytes, index pulses, seek answers
// assumes the bench calls its tasks just after a rising pclk edge
`timescale 1ns/10ps
module fdx_drive_model #(
  parameter int SEEK_WAIT = 20,
  parameter logic [7:0] FAIL_CYL = 8'h03
) (
  input wire logic pclk,
  input wire logic seek_req,
  input wire logic seek_good,
  output logic index_pulse_input_n,
  output logic id_valid,
  output logic [7:0] id_cyl,
  output logic [7:0] id_head,
  output logic [7:0] id_sec,
  output logic [7:0] id_size,
  output logic id_crc_ok,
  output logic mark_valid,
  output logic mark_deleted,
  output logic byte_valid,
  output logic [7:0] byte_data,
  output logic field_end,
  output logic field_crc_ok,
  output logic seek_done,
  output logic seek_ok,
  output logic [7:0] seek_fail_cyl
);
  int cnt = 0;
  assign seek_fail_cyl = FAIL_CYL;
  initial begin
    index_pulse_input_n = 1'b1;
    {id_valid, mark_valid, byte_valid, field_end} = '0;
    {id_cyl, id_head, id_sec, id_size, byte_data} = '0;
    {id_crc_ok, mark_deleted, field_crc_ok} = '0;
  end
  // ****************
  // disk strobes
  // ****************
  // ends a strobe and leaves one idle cycle; strobes clear and id_sec, byte_data flip so nothing stale looks valid
  task automatic gap();
    @(posedge pclk);
    {id_valid, mark_valid, byte_valid, field_end} <= 4'h0;
    id_sec <= ~id_sec;
    byte_data <= ~byte_data;
    @(posedge pclk);
  endtask
  task automatic sector(input logic [7:0] c, input logic [7:0] s, input logic del,
      input logic idok, input logic dok, input logic [7:0] b);
    int i;
    @(posedge pclk);
    id_cyl <= c;
    id_head <= 8'h00;
    id_sec <= s;
    id_size <= 8'h00;
    id_crc_ok <= idok;
    id_valid <= 1'b1;
    gap();
    mark_deleted <= del;
    mark_valid <= 1'b1;
    gap();
    for (i = 0; i < 128; i++) begin
      byte_data <= b + i[7:0];
      byte_valid <= 1'b1;
      gap();
    end
    field_crc_ok <= dok;
    field_end <= 1'b1;
    gap();
  endtask
  task automatic index();
    repeat (4) @(posedge pclk);
    index_pulse_input_n <= 1'b0;
    repeat (4) @(posedge pclk);
    index_pulse_input_n <= 1'b1;
  endtask
  // ****************
  // seek answers
  // ****************
  // a slow seek, so the bench can see busy while it runs
  always @(posedge pclk) begin
    if (seek_req && !seek_done && cnt == SEEK_WAIT) begin
      seek_done <= 1'b1;
      seek_ok <= seek_good;
      cnt <= 0;
    end else begin
      seek_done <= 1'b0;
      seek_ok <= ~seek_good;
      cnt <= seek_req ? cnt + 1 : 0;
    end
  end
endmodule

// file: bench/fdx_engine_tb_top.sv
// bench for the read engine: apb host tasks, drive stand-in, scenarios
// assumes the design files and the drive stand-in compile first
`timescale 1ns/10ps
`include "fdx_defines.svh"
module floppy_read_data_command_engine_tb_top;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [31:0] pwdata = 32'h0000_0000;
  logic seek_good = 1'b1;
  logic [31:0] rdv;
  logic slv;
  logic [7:0] rb [7];
  int failures = 0;
  int samples_checked = 0;
  wire logic [31:0] prdata;
  wire logic pready, pslverr, index_pulse_input_n, id_valid, id_crc_ok, mark_valid;
  wire logic mark_deleted, byte_valid, field_end, field_crc_ok, seek_req, seek_done;
  wire logic seek_ok, head_load, head_select, wr_data_valid;
  wire logic [7:0] id_cyl, id_head, id_sec, id_size, byte_data, seek_cyl, seek_fail_cyl, wr_data;
  always #5 pclk = ~pclk;
  fdx_engine #(.STEP_CYCLES(4)) uut (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .index_pulse_input_n, .id_valid, .id_cyl, .id_head,
    .id_sec, .id_size, .id_crc_ok, .mark_valid, .mark_deleted, .byte_valid, .byte_data,
    .field_end, .field_crc_ok, .seek_req, .seek_cyl, .seek_done, .seek_ok, .seek_fail_cyl,
    .head_load, .head_select, .wr_data, .wr_data_valid);
  fdx_drive_model drv (.pclk, .seek_req, .seek_good, .index_pulse_input_n, .id_valid,
    .id_cyl, .id_head, .id_sec, .id_size, .id_crc_ok, .mark_valid, .mark_deleted, .byte_valid,
    .byte_data, .field_end, .field_crc_ok, .seek_done, .seek_ok, .seek_fail_cyl);
  // ****************
  // host tasks
  // ****************
  task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic ap(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rdv = prdata;
    slv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ap(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    ap(1'b0, a, 32'h0000_0000);
  endtask
  task automatic cmd(input logic [7:0] op, input logic [7:0] c, input logic [7:0] s,
      input logic [7:0] final_sector_number, input logic [7:0] short_length);
    logic [7:0] b [9];
    int i;
    b = '{op, 8'h00, c, 8'h00, s, 8'h00, final_sector_number, 8'h1B, short_length};
    for (i = 0; i < 9; i++) wr(`FDX_A_CMD, {24'h00_0000, b[i]});
  endtask
  // polls status; bounded so a stuck engine cannot hang the run
  task automatic go(input logic [2:0] st);
    int n;
    n = 0;
    do begin
      rd(`FDX_A_STAT);
      n++;
    end while (rdv[6:4] !== st && n < 300);
    cmp("state", st, rdv[6:4]);
  endtask
  task automatic pop(input int n, input logic [7:0] b);
    int i;
    for (i = 0; i < n; i++) begin
      rd(`FDX_A_DATA);
      cmp("data", b + i[7:0], rdv[7:0]);
    end
  endtask
  task automatic res(input logic [7:0] e [7], input logic [6:0] m);
    int i;
    for (i = 0; i < 7; i++) begin
      rd(`FDX_A_RES);
      rb[i] = rdv[7:0];
      if (m[i]) cmp("result", e[i], rb[i]);
    end
  endtask
  // ****************
  // scenarios
  // ****************
  task automatic s_basic();
    cmd(8'h06, 8'h00, 8'h01, 8'h01, 8'h04);
    rd(`FDX_A_STAT);
    cmp("settle", 2, rdv[6:4]);
    cmp("head_load", 1, head_load);
    go(3);
    drv.sector(8'h00, 8'h01, 1'b0, 1'b1, 1'b1, 8'h10);
    pop(4, 8'h10);
    go(5);
    cmp("head_kept", 1, head_load);
    cmp("fifo_empty", 1, rdv[8]);
    res('{0, 0, 0, 1, 0, 1, 0}, 7'h7F);
    rd(`FDX_A_STAT);
    cmp("idle", 0, rdv[6:4]);
  endtask
  task automatic s_multi();
    cmd(8'h06, 8'h00, 8'h01, 8'h02, 8'h02);
    rd(`FDX_A_STAT);
    cmp("no_settle", 3, rdv[6:4]);
    drv.sector(8'h00, 8'h01, 1'b0, 1'b1, 1'b1, 8'h20);
    pop(2, 8'h20);
    rd(`FDX_A_STAT);
    cmp("next", 3, rdv[6:4]);
    drv.sector(8'h00, 8'h02, 1'b0, 1'b1, 1'b1, 8'h30);
    pop(2, 8'h30);
    go(5);
    res('{0, 0, 0, 1, 0, 1, 0}, 7'h7F);
  endtask
  task automatic s_tc();
    int k;
    cmd(8'h06, 8'h00, 8'h01, 8'h05, 8'h08);
    go(3);
    fork
      drv.sector(8'h00, 8'h01, 1'b0, 1'b1, 1'b1, 8'h40);
      begin
        repeat (3) @(posedge byte_valid);
        wr(`FDX_A_TC, 32'h0000_0001);
      end
    join
    go(5);
    k = 0;
    rd(`FDX_A_STAT);
    while (rdv[8] !== 1'b1 && k < 16) begin
      rd(`FDX_A_DATA);
      cmp("data", 8'h40 + k[7:0], rdv[7:0]);
      k++;
      rd(`FDX_A_STAT);
    end
    cmp("tc_stop", 1, k < 8);
    res('{0, 0, 0, 0, 0, 2, 0}, 7'h7F);
    cmd(8'h06, 8'h00, 8'h01, 8'h05, 8'hFF);
    go(3);
    drv.sector(8'h00, 8'h01, 1'b0, 1'b1, 1'b1, 8'h48);
    go(5);
    res('{0, 0, 0, 0, 0, 2, 0}, 7'h28);
    pop(16, 8'h48);
  endtask
  task automatic s_nodata();
    cmd(8'h06, 8'h00, 8'h09, 8'h09, 8'h04);
    go(3);
    drv.sector(8'h00, 8'h03, 1'b0, 1'b1, 1'b1, 8'h00);
    drv.index();
    rd(`FDX_A_STAT);
    cmp("one_index", 3, rdv[6:4]);
    drv.index();
    go(5);
    res('{8'h40, 8'h04, 0, 0, 0, 0, 0}, 7'h03);
  endtask
  task automatic s_crc();
    int i;
    for (i = 0; i < 2; i++) begin
      cmd(8'h06, 8'h00, 8'h01, 8'h01, 8'h04);
      go(3);
      drv.sector(8'h00, 8'h01, 1'b0, i[0], ~i[0], 8'h50);
      if (i == 1) pop(4, 8'h50);
      go(5);
      res('{8'h40, 8'h20, (i == 1) ? 8'h00 : 8'h20, 0, 0, 0, 0}, 7'h07);
    end
  endtask
  // mark type against skip bit, for both read commands
  task automatic s_skip();
    logic [7:0] op [5];
    logic [4:0] del;
    logic r;
    int i;
    op = '{8'h06, 8'h0C, 8'h26, 8'h2C, 8'h0C};
    del = 5'b10101;
    for (i = 0; i < 5; i++) begin
      cmd(op[i], 8'h00, 8'h01, (i < 2) ? 8'h02 : 8'h01, 8'h04);
      go(3);
      drv.sector(8'h00, 8'h01, del[i], 1'b1, 1'b1, 8'h60);
      go(5);
      r = (i != 2 && i != 3);
      if (r) pop(4, 8'h60);
      if (!r) cmp("skipped", 1, rdv[8]);
      res('{0, 0, (i < 4) ? 8'h40 : 8'h00, i == 4, 0, 1, 0}, r ? 7'h2C : 7'h05);
    end
  endtask
  task automatic s_seek();
    wr(`FDX_A_CFG, 32'h000F_F021);
    cmd(8'h06, 8'h05, 8'h01, 8'h01, 8'h04);
    rd(`FDX_A_STAT);
    cmp("drive_busy", 1, rdv[1]);
    cmp("seek_req", 1, seek_req);
    cmp("seek_cyl", 5, seek_cyl);
    go(3);
    drv.sector(8'h05, 8'h01, 1'b0, 1'b1, 1'b1, 8'h70);
    pop(4, 8'h70);
    go(5);
    res('{0, 0, 0, 6, 0, 1, 0}, 7'h7F);
    seek_good <= 1'b0;
    cmd(8'h06, 8'h09, 8'h01, 8'h01, 8'h04);
    go(5);
    res('{0, 0, 0, 8'h03, 0, 0, 0}, 7'h08);
    cmp("seek_error", 1, rb[0][5]);
  endtask
  task automatic s_misc();
    wr(`FDX_A_CFG, 32'h0000_1020);
    cmd(8'h1F, 8'h00, 8'h01, 8'h01, 8'h04);
    go(5);
    res('{0, 0, 0, 0, 0, 0, 0}, 7'h00);
    cmp("bad_code", 2, rb[0][7:6]);
    rd(8'h18);
    cmp("slverr", 1, slv);
    cmp("unmapped", 0, rdv);
    cmd(8'h05, 8'h00, 8'h01, 8'h01, 8'h01);
    wr(`FDX_A_DATA, 32'h0000_00A5);
    go(3);
    fork
      drv.sector(8'h00, 8'h01, 1'b0, 1'b1, 1'b1, 8'h00);
      begin
        do @(posedge pclk); while (wr_data_valid !== 1'b1);
        cmp("wr_data", 8'hA5, wr_data);
        do @(posedge pclk); while (wr_data_valid !== 1'b1);
        cmp("wr_pad", 0, wr_data);
      end
    join
    go(5);
    res('{0, 0, 0, 1, 0, 1, 0}, 7'h28);
    repeat (1100) @(posedge pclk);
    cmp("unloaded", 0, head_load);
  endtask
  task automatic test_done();
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(`FDX_A_CFG);
    cmp("cfg_reset", `FDX_CFG_RST, rdv);
    wr(`FDX_A_CFG, 32'h000F_F020);
    s_basic();
    s_multi();
    s_tc();
    s_nodata();
    s_crc();
    s_skip();
    s_seek();
    s_misc();
    test_done();
  end
  // the whole run needs well under half of this span
  initial begin
    #1000000;
    failures++;
    test_done();
  end
endmodule

// file: rtl/fdx_defines.svh
// offsets, field positions, reset values and timing counts of the read engine
// assumes inclusion by every file that needs them, once per compile unit
`ifndef FDX_DEFINES_SVH
`define FDX_DEFINES_SVH
// ****************
// register offsets
// ****************
`define FDX_A_CMD 8'h00
`define FDX_A_STAT 8'h04
`define FDX_A_RES 8'h08
`define FDX_A_DATA 8'h0C
`define FDX_A_CFG 8'h10
`define FDX_A_TC 8'h14
// ****************
// fields
// ****************
`define FDX_CFG_RST 20'h0_2010
`define FDX_CFG_SEEK 0
`define FDX_ST0_SE 5
`define FDX_ST1_ND 2
`define FDX_ST1_DE 5
`define FDX_ST2_DD 5
`define FDX_ST2_CM 6
`define FDX_OP_READ 5'h06
`define FDX_OP_RDEL 5'h0C
`define FDX_OP_WRITE 5'h05
`define FDX_OP_WDEL 5'h09
`define FDX_OP_VERIFY 5'h16
`define FDX_IC_ABN 2'b01
`define FDX_IC_BAD 2'b10
`define FDX_PRM_LAST 4'h8
`define FDX_RES_LAST 3'h6
`define FDX_BASE_LEN 15'h0080
// ****************
// timing
// ****************
`define FDX_CLK_NS 10
`define FDX_STEP_NS 1000000
`endif

// file: rtl/fdx_engine.sv
// execution sequencer for the data transfer commands, with apb registers
// assumes disk-side strobes are pclk logic; only the index pin is asynchronous
//
// What this block does
// - read, write, verify share nine parameter bytes; low five opcode bits pick
// - implied seek runs first when enabled, drive busy shown meanwhile
// - failed seek ends command, first status code plus failing cylinder
// - load head, wait settle time, search ids, move matching sector to fifo
// - after each sector, sector number plus one, continue with next
// - terminal count or overrun stops host data, sector finishes, then end
// - sector length is 128 bytes shifted left by size code
// - size zero, short length below 128: only that many bytes passed on
// - size zero short write pads rest of 128-byte sector with zeros
// - multi-track runs side 0 sector 1 through last sector of side 1
// - result identifiers at host stop depend on multi-track and final sector
// - head stays loaded for unload interval; new command skips settling
// - two index pulses without sector: code 01, no-data flag, end
// - crc error: code 01, crc error flag, end; field crc flag only on an id field crc error
// - read with mismatched mark: skip clear reads and stops, set skips
// - sector address advances automatically except after a data crc error or a mismatched mark read with skip clear
// - read deleted behaves as read but targets deleted marks
// - read deleted swaps mark roles for control-mark and skipping
//
// The implementer's own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
`include "fdx_defines.svh"
module fdx_engine import fdx_pkg::*; #(
  parameter int STEP_CYCLES = `FDX_STEP_NS / `FDX_CLK_NS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic index_pulse_input_n,
  input wire logic id_valid,
  input wire logic [7:0] id_cyl,
  input wire logic [7:0] id_head,
  input wire logic [7:0] id_sec,
  input wire logic [7:0] id_size,
  input wire logic id_crc_ok,
  input wire logic mark_valid,
  input wire logic mark_deleted,
  input wire logic byte_valid,
  input wire logic [7:0] byte_data,
  input wire logic field_end,
  input wire logic field_crc_ok,
  output logic seek_req,
  output logic [7:0] seek_cyl,
  input wire logic seek_done,
  input wire logic seek_ok,
  input wire logic [7:0] seek_fail_cyl,
  output logic head_load,
  output logic head_select,
  output logic [7:0] wr_data,
  output logic wr_data_valid
);
  fdx_state_t st_r;
  logic [7:0] prm_r [0:8];
  logic [3:0] pcnt_r;
  logic ack_r;
  logic [19:0] cfg_r;
  logic [7:0] cyl_r, hd_r, sec_r, cur_cyl_r;
  logic [1:0] ic_r;
  logic se_r, nd_r, de_r, dd_r, cm_r;
  logic [2:0] res_idx_r;
  logic matched_r, no_inc_r, stop_r, pad_r;
  logic [1:0] idx_cnt_r;
  logic [14:0] bcnt_r;
  logic [23:0] tick_r;
  logic [7:0] wait_r, ul_r;
  logic head_loaded_r;
  logic [2:0] idx_sync_r;
  logic [7:0] fifo_rd, fifo_wd;
  logic fifo_full, fifo_empty, fifo_push, fifo_pop;
  fdx_kind_t kind;
  logic acc, done, hit, cmd_wr, res_pop, apb_push, apb_pop, tc_wr;
  logic step, idx_pulse, mt, skip, is_del, pass, wpass, last, more, start;
  logic [14:0] sect_len, limit;
  logic [7:0] sec_nxt, hd_nxt, cyl_nxt, res_byte;

  // ****************
  // apb slave, one wait state on every access
  // ****************
  assign acc = psel && penable;
  assign done = acc && ack_r;
  assign pready = ack_r;
  assign hit = (paddr <= `FDX_A_TC) && (paddr[1:0] == 2'b00);
  assign pslverr = ack_r && !hit;
  assign cmd_wr = done && pwrite && (paddr == `FDX_A_CMD) && (st_r == ST_IDLE);
  assign res_pop = done && !pwrite && (paddr == `FDX_A_RES) && (st_r == ST_RESULT);
  assign tc_wr = done && pwrite && (paddr == `FDX_A_TC);
  assign apb_push = done && pwrite && (paddr == `FDX_A_DATA) && (kind == K_WRITE);
  // pop in the first access cycle so registered fifo data is there at pready
  assign apb_pop = acc && !ack_r && !pwrite && (paddr == `FDX_A_DATA) &&
                   (kind == K_READ) && !fifo_empty;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ack_r <= 1'b0;
      cfg_r <= `FDX_CFG_RST;
    end else begin
      ack_r <= acc && !ack_r;
      if (done && pwrite && (paddr == `FDX_A_CFG)) begin
        cfg_r <= pwdata[19:0];
      end
    end
  end

  always_comb begin
    case (res_idx_r)
      3'h0: res_byte = {ic_r, se_r, 2'b00, hd_r[0], prm_r[1][1:0]};
      3'h1: res_byte = 8'(de_r) << `FDX_ST1_DE | 8'(nd_r) << `FDX_ST1_ND;
      3'h2: res_byte = 8'(cm_r) << `FDX_ST2_CM | 8'(dd_r) << `FDX_ST2_DD;
      3'h3: res_byte = cyl_r;
      3'h4: res_byte = hd_r;
      3'h5: res_byte = sec_r;
      default: res_byte = prm_r[5];
    endcase
    case (paddr)
      `FDX_A_CMD: prdata = {28'h000_0000, pcnt_r};
      `FDX_A_STAT: prdata = {22'h00_0000, fifo_full, fifo_empty, 1'b0, st_r,
                             head_loaded_r, st_r == ST_RESULT, seek_req,
                             st_r != ST_IDLE};
      `FDX_A_RES: prdata = {24'h00_0000, res_byte};
      `FDX_A_DATA: prdata = {24'h00_0000, fifo_rd};
      `FDX_A_CFG: prdata = {12'h000, cfg_r};
      default: prdata = 32'h0000_0000;
    endcase
  end

  // ****************
  // command bytes and decode
  // ****************
  assign start = cmd_wr && (pcnt_r == `FDX_PRM_LAST);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pcnt_r <= 4'h0;
      for (int i = 0; i < 9; i++) begin
        prm_r[i] <= 8'h00;
      end
    end else if (cmd_wr) begin
      prm_r[pcnt_r] <= pwdata[7:0];
      pcnt_r <= start ? 4'h0 : 4'(pcnt_r + 4'h1);
    end
  end

  always_comb begin
    case (prm_r[0][4:0])
      `FDX_OP_READ, `FDX_OP_RDEL: kind = K_READ;
      `FDX_OP_WRITE, `FDX_OP_WDEL: kind = K_WRITE;
      `FDX_OP_VERIFY: kind = K_VERIFY;
      default: kind = K_BAD;
    endcase
  end
  assign mt = prm_r[0][7];
  assign skip = prm_r[0][5];
  assign is_del = (prm_r[0][4:0] == `FDX_OP_RDEL);

  // sector length and count of bytes that reach the host
  assign sect_len = 15'(`FDX_BASE_LEN << prm_r[5][2:0]);
  // a nonzero size code ignores the short length entirely
  assign limit = (prm_r[5] == 8'h00 && prm_r[8] < 8'h80) ?
                 {7'h00, prm_r[8]} : sect_len;
  assign pass = !stop_r && (bcnt_r < limit);
  assign wpass = pass && (kind == K_WRITE);

  // next sector address
  assign last = (sec_r == prm_r[6]);
  always_comb begin
    sec_nxt = 8'(sec_r + 8'h01);
    hd_nxt = hd_r;
    cyl_nxt = cyl_r;
    more = 1'b1;
    if (last) begin
      sec_nxt = 8'h01;
      if (mt && !hd_r[0]) begin
        hd_nxt = 8'h01;
      end else begin
        cyl_nxt = 8'(cyl_r + 8'h01);
        hd_nxt = mt ? {hd_r[7:1], ~hd_r[0]} : hd_r;
        more = 1'b0;
      end
    end
  end

  // ****************
  // index pin synchroniser and step timer
  // ****************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      idx_sync_r <= 3'b111;
      tick_r <= 24'h00_0000;
    end else begin
      idx_sync_r <= {idx_sync_r[1:0], index_pulse_input_n};
      tick_r <= step ? 24'h00_0000 : 24'(tick_r + 24'h00_0001);
    end
  end
  assign idx_pulse = idx_sync_r[2] && !idx_sync_r[1];
  assign step = (tick_r == 24'(STEP_CYCLES - 1));

  // ****************
  // data fifo
  // ****************
  assign fifo_wd = (kind == K_READ) ? byte_data : pwdata[7:0];
  assign fifo_push = (kind == K_READ) ?
    (st_r == ST_DATA && byte_valid && pass && !fifo_full) :
    (apb_push && !fifo_full);
  assign fifo_pop = apb_pop || (st_r == ST_DATA && byte_valid && wpass && !fifo_empty);

  fdx_fifo u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .push(fifo_push),
    .wdata(fifo_wd),
    .pop(fifo_pop),
    .rdata(fifo_rd),
    .full(fifo_full),
    .empty(fifo_empty)
  );

  // write byte to the disk: fifo data, or zeros once the host part is done
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_data_valid <= 1'b0;
      pad_r <= 1'b1;
    end else begin
      wr_data_valid <= st_r == ST_DATA && byte_valid && kind == K_WRITE;
      pad_r <= !(wpass && !fifo_empty);
    end
  end
  assign wr_data = pad_r ? 8'h00 : fifo_rd;

  // ****************
  // head load and unload timing
  // ****************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      head_loaded_r <= 1'b0;
      ul_r <= 8'h00;
      wait_r <= 8'h00;
    end else begin
      wait_r <= (st_r != ST_SETTLE) ? 8'h00 : step ? 8'(wait_r + 8'h01) : wait_r;
      if (st_r == ST_SETTLE) begin
        head_loaded_r <= 1'b1;
      end
      // stays loaded for the unload interval after the command
      if (st_r != ST_IDLE) begin
        ul_r <= 8'h00;
      end else if (head_loaded_r && step) begin
        ul_r <= 8'(ul_r + 8'h01);
        if (ul_r >= cfg_r[19:12]) begin
          head_loaded_r <= 1'b0;
        end
      end
    end
  end
  assign head_load = head_loaded_r || (st_r == ST_SETTLE);
  assign head_select = hd_r[0];
  assign seek_req = (st_r == ST_SEEK);
  assign seek_cyl = cyl_r;

  // ****************
  // execution sequencer
  // ****************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= ST_IDLE;
      cyl_r <= 8'h00;
      hd_r <= 8'h00;
      sec_r <= 8'h00;
      cur_cyl_r <= 8'h00;
      ic_r <= 2'b00;
      {se_r, nd_r, de_r, dd_r, cm_r} <= 5'b00000;
      {matched_r, no_inc_r, stop_r} <= 3'b000;
      idx_cnt_r <= 2'b00;
      bcnt_r <= 15'h0000;
      res_idx_r <= 3'h0;
    end else begin
      if (tc_wr && st_r != ST_IDLE && st_r != ST_RESULT) begin
        stop_r <= 1'b1;
      end
      case (st_r)
        ST_IDLE: begin
          res_idx_r <= 3'h0;
          if (start) begin
            cyl_r <= prm_r[2];
            hd_r <= prm_r[3];
            sec_r <= prm_r[4];
            ic_r <= 2'b00;
            {se_r, nd_r, de_r, dd_r, cm_r} <= 5'b00000;
            {matched_r, no_inc_r, stop_r} <= 3'b000;
            idx_cnt_r <= 2'b00;
            if (kind == K_BAD) begin
              ic_r <= `FDX_IC_BAD;
              st_r <= ST_RESULT;
            end else if (cfg_r[`FDX_CFG_SEEK] && prm_r[2] != cur_cyl_r) begin
              st_r <= ST_SEEK;
            end else begin
              st_r <= head_loaded_r ? ST_SEARCH : ST_SETTLE;
            end
          end
        end
        ST_SEEK: begin
          if (seek_done && seek_ok) begin
            cur_cyl_r <= cyl_r;
            st_r <= head_loaded_r ? ST_SEARCH : ST_SETTLE;
          end else if (seek_done) begin
            ic_r <= `FDX_IC_ABN;
            se_r <= 1'b1;
            cyl_r <= seek_fail_cyl;
            st_r <= ST_RESULT;
          end
        end
        ST_SETTLE: begin
          if (wait_r >= cfg_r[11:4]) begin
            st_r <= ST_SEARCH;
          end
        end
        ST_SEARCH: begin
          if (idx_pulse) begin
            idx_cnt_r <= 2'(idx_cnt_r + 2'b01);
            if (idx_cnt_r == 2'b01) begin
              ic_r <= `FDX_IC_ABN;
              nd_r <= 1'b1;
              st_r <= ST_RESULT;
            end
          end
          if (id_valid && !id_crc_ok) begin
            ic_r <= `FDX_IC_ABN;
            de_r <= 1'b1;
            dd_r <= 1'b1;
            st_r <= ST_RESULT;
          end else if (id_valid) begin
            matched_r <= {id_cyl, id_head, id_sec, id_size} ==
                         {cyl_r, hd_r, sec_r, prm_r[5]};
            if ({id_cyl, id_head, id_sec} == {cyl_r, hd_r, sec_r}) begin
              idx_cnt_r <= 2'b00;
            end
          end else if (mark_valid && matched_r) begin
            matched_r <= 1'b0;
            bcnt_r <= 15'h0000;
            if (kind == K_READ && (mark_deleted ^ is_del)) begin
              cm_r <= 1'b1;
              if (skip) begin
                sec_r <= sec_nxt;
                hd_r <= hd_nxt;
                cyl_r <= cyl_nxt;
                st_r <= more ? ST_SEARCH : ST_RESULT;
              end else begin
                no_inc_r <= 1'b1;
                st_r <= ST_DATA;
              end
            end else begin
              st_r <= ST_DATA;
            end
          end
        end
        ST_DATA: begin
          if (byte_valid) begin
            bcnt_r <= 15'(bcnt_r + 15'h0001);
            // overrun or underrun acts as a terminal count
            if ((kind == K_READ && pass && fifo_full) || (wpass && fifo_empty)) begin
              stop_r <= 1'b1;
            end
          end
          if (field_end && !field_crc_ok) begin
            ic_r <= `FDX_IC_ABN;
            de_r <= 1'b1;
            st_r <= ST_RESULT;
          end else if (field_end && no_inc_r) begin
            st_r <= ST_RESULT;
          end else if (field_end) begin
            sec_r <= sec_nxt;
            hd_r <= hd_nxt;
            cyl_r <= cyl_nxt;
            idx_cnt_r <= 2'b00;
            st_r <= (more && !stop_r) ? ST_SEARCH : ST_RESULT;
          end
        end
        ST_RESULT: begin
          if (res_pop) begin
            res_idx_r <= 3'(res_idx_r + 3'h1);
            if (res_idx_r == `FDX_RES_LAST) begin
              st_r <= ST_IDLE;
            end
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // ****************
  // checks
  // ****************
  seek_busy_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == ST_SEEK |-> seek_req && (paddr != `FDX_A_STAT || prdata[1:0] == 2'b11))
    else $error("drive busy not shown during seek");
  seek_fail_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == ST_SEEK && seek_done && !seek_ok |=>
    st_r == ST_RESULT && ic_r == 2'b01 && cyl_r == $past(seek_fail_cyl))
    else $error("seek failure not reported");
  settle_head_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == ST_SETTLE && wait_r < cfg_r[11:4] |=> st_r == ST_SETTLE && head_load)
    else $error("settle wait cut short");
  sector_inc_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == ST_DATA && field_end && field_crc_ok && !no_inc_r && !last |=>
    sec_r == 8'($past(sec_r) + 8'h01))
    else $error("sector number not advanced");
  overrun_stop_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == ST_DATA && byte_valid && kind == K_READ && pass && fifo_full |=>
    stop_r [*2])
    else $error("overrun did not stop host transfer");
  short_len_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == ST_DATA && bcnt_r >= limit |-> !fifo_push || kind != K_READ)
    else $error("byte passed beyond short length");
  write_pad_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == ST_DATA && byte_valid && kind == K_WRITE && !pass |=>
    wr_data_valid && wr_data == 8'h00)
    else $error("write not padded with zeros");
  index_miss_a: assert property (@(posedge pclk) disable iff (!presetn)
    st_r == ST_SEARCH && idx_pulse && idx_cnt_r == 2'b01 |=>
    st_r == ST_RESULT && nd_r && ic_r == 2'b01)
    else $error("missing sector not reported after two index pulses");
endmodule

// file: rtl/fdx_fifo.sv
// sixteen byte data fifo with registered read data
// assumes one clock domain; pop only when not empty, push only when not full
`timescale 1ns/10ps
module fdx_fifo (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic push,
  input wire logic [7:0] wdata,
  input wire logic pop,
  output logic [7:0] rdata,
  output logic full,
  output logic empty
);
  logic [7:0] mem [0:15];
  logic [4:0] wp_r;
  logic [4:0] rp_r;

  assign full = (wp_r[3:0] == rp_r[3:0]) && (wp_r[4] != rp_r[4]);
  assign empty = (wp_r == rp_r);

  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wp_r[3:0]] <= wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp_r <= 5'h00;
      rp_r <= 5'h00;
      rdata <= 8'h00;
    end else begin
      if (push) begin
        wp_r <= 5'(wp_r + 5'h01);
      end
      if (pop) begin
        rp_r <= 5'(rp_r + 5'h01);
        rdata <= mem[rp_r[3:0]];
      end
    end
  end
endmodule

// file: rtl/fdx_pkg.sv
// types used by the read engine: sequencer states and command kinds
// assumes nothing of its surroundings
package fdx_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_SEEK = 3'b001,
    ST_SETTLE = 3'b010,
    ST_SEARCH = 3'b011,
    ST_DATA = 3'b100,
    ST_RESULT = 3'b101
  } fdx_state_t;
  typedef enum logic [1:0] {
    K_READ = 2'b00,
    K_WRITE = 2'b01,
    K_VERIFY = 2'b10,
    K_BAD = 2'b11
  } fdx_kind_t;
endpackage
